// ==== hdl/nfc_bus_cycle.sv ====
// One bus cycle on the flash port: command, address, write or read byte
`timescale 1ns/1ps
`include "nfc_params.svh"
module nfc_bus_cycle (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Request
  input wire logic start_in,
  input wire nfc_pkg::nfc_kind_t kind_in,
  input wire logic [7:0] byte_in,
  output logic done_out,
  output logic [7:0] rdata_out,
  // Flash pins
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic output_strobe_n_out,
  output logic [7:0] io_out,
  output logic io_oe_n_out,
  input wire logic [7:0] io_in
);
  localparam int WE_LOW_C = `NFC_WE_LOW_CYC;

  nfc_pkg::nfc_cyc_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rd_reg, rd_next;
  logic done_reg, done_next;
  logic [7:0] rdata_reg, rdata_next;
  logic cle_reg, cle_next, ale_reg, ale_next;
  logic we_n_reg, we_n_next, re_n_reg, re_n_next;
  logic [7:0] io_reg, io_next;
  logic oe_n_reg, oe_n_next;

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    cle_next = cle_reg;
    ale_next = ale_reg;
    we_n_next = we_n_reg;
    re_n_next = re_n_reg;
    io_next = io_reg;
    oe_n_next = oe_n_reg;
    unique case (state_reg)
      nfc_pkg::NFC_CY_IDLE: begin
        if (start_in) begin
          // Latch strobes set up before the strobe falls
          cle_next = (kind_in == nfc_pkg::NFC_KIND_CMD);
          ale_next = (kind_in == nfc_pkg::NFC_KIND_ADDR);
          rd_next = (kind_in == nfc_pkg::NFC_KIND_RDATA);
          io_next = byte_in;
          // Bus released for reads so the device alone drives it
          oe_n_next = (kind_in == nfc_pkg::NFC_KIND_RDATA);
          state_next = nfc_pkg::NFC_CY_SETUP;
        end
      end
      nfc_pkg::NFC_CY_SETUP: begin
        we_n_next = rd_reg;
        re_n_next = !rd_reg;
        cnt_next = (rd_reg ? `NFC_RD_LOW_CYC : `NFC_WE_LOW_CYC) - 4'h1;
        state_next = nfc_pkg::NFC_CY_LOW;
      end
      nfc_pkg::NFC_CY_LOW: begin
        if (cnt_reg == 4'h0) begin
          we_n_next = 1'b1;
          re_n_next = 1'b1;
          // Sample once the access delay has passed
          if (rd_reg) begin
            rdata_next = io_in;
          end
          cnt_next = `NFC_HIGH_CYC - 4'h1;
          state_next = nfc_pkg::NFC_CY_HIGH;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      nfc_pkg::NFC_CY_HIGH: begin
        if (cnt_reg == 4'h0) begin
          cle_next = 1'b0;
          ale_next = 1'b0;
          oe_n_next = 1'b1;
          done_next = 1'b1;
          state_next = nfc_pkg::NFC_CY_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= nfc_pkg::NFC_CY_IDLE;
      cnt_reg <= 4'h0;
      rd_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 8'h00;
      cle_reg <= 1'b0;
      ale_reg <= 1'b0;
      we_n_reg <= 1'b1;
      re_n_reg <= 1'b1;
      io_reg <= 8'h00;
      oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      cle_reg <= cle_next;
      ale_reg <= ale_next;
      we_n_reg <= we_n_next;
      re_n_reg <= re_n_next;
      io_reg <= io_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign done_out = done_reg;
  assign rdata_out = rdata_reg;
  assign cle_out = cle_reg;
  assign ale_out = ale_reg;
  assign we_n_out = we_n_reg;
  assign output_strobe_n_out = re_n_reg;
  assign io_out = io_reg;
  assign io_oe_n_out = oe_n_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_latch_exclusive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(cle_reg && ale_reg)) else $error("command and address latch both high");
  a_we_drives_bus: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !we_n_reg |-> (!oe_n_reg && re_n_reg)) else $error("write strobe low without driving bus");
  a_we_pulse_width: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(we_n_reg) |-> ##WE_LOW_C $rose(we_n_reg)) else $error("write strobe low time wrong");
  a_read_floats: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !re_n_reg |-> (oe_n_reg && !cle_reg && !ale_reg)) else $error("host drives bus while reading");
  a_read_access: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(re_n_reg) |-> !re_n_reg [*2] ##1 re_n_reg) else $error("output strobe low time wrong");
  a_cycle_ends: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (start_in && state_reg == nfc_pkg::NFC_CY_IDLE) |-> ##[2:40] done_reg) else $error("bus cycle never ends");

endmodule // nfc_bus_cycle

// ==== hdl/nfc_host.sv ====
// Host-side command sequencer for a multi-die NAND flash port
`timescale 1ns/1ps
`include "nfc_params.svh"
module nfc_host (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Operation request
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire nfc_pkg::nfc_op_t cmd_op_in,
  input wire logic [1:0] cmd_die_in,
  input wire logic [11:0] cmd_col_in,
  input wire logic [18:0] cmd_row_in,
  input wire logic [11:0] cmd_len_in,
  output logic done_out,
  // Write data stream
  input wire logic [7:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  // Read data stream
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Flash pins
  output logic [3:0] ce_n_out,
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic output_strobe_n_out,
  output logic wp_n_out,
  output logic [7:0] io_out,
  output logic io_oe_n_out,
  input wire logic [7:0] io_in,
  input wire logic [3:0] rb_in
);
  nfc_pkg::nfc_state_t state_reg, state_next;
  nfc_pkg::nfc_op_t op_reg, op_next;
  logic [1:0] die_reg, die_next;
  logic [11:0] col_reg, col_next;
  logic [18:0] row_reg, row_next;
  logic [11:0] len_reg, len_next;
  logic [11:0] cnt_reg, cnt_next;
  logic [2:0] aidx_reg, aidx_next;
  logic [2:0] alast_reg, alast_next;
  logic [2:0] acnt_reg, acnt_next;
  logic [3:0] wait_reg, wait_next;
  logic pend_reg, pend_next;
  logic [3:0] ce_n_reg, ce_n_next;
  logic wp_n_reg, wp_n_next;
  logic done_reg, done_next;
  logic rd_valid_reg, rd_valid_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic eng_start;
  nfc_pkg::nfc_kind_t eng_kind;
  logic [7:0] eng_byte;
  logic eng_done;
  logic [7:0] eng_rdata;
  logic bus_state;
  logic busy_ok;

  function automatic logic [7:0] first_code(input nfc_pkg::nfc_op_t op);
    unique case (op)
      nfc_pkg::NFC_OP_READ: first_code = `NFC_CMD_READ_SETUP;
      nfc_pkg::NFC_OP_PROGRAM: first_code = `NFC_CMD_PROG_SETUP;
      nfc_pkg::NFC_OP_ERASE: first_code = `NFC_CMD_ERASE_SETUP;
      nfc_pkg::NFC_OP_RESET: first_code = `NFC_CMD_RESET;
      nfc_pkg::NFC_OP_STATUS: first_code = `NFC_CMD_STATUS;
      nfc_pkg::NFC_OP_READ_ID: first_code = `NFC_CMD_READ_ID;
      default: first_code = `NFC_CMD_STATUS;
    endcase
  endfunction

  function automatic logic [7:0] second_code(input nfc_pkg::nfc_op_t op);
    unique case (op)
      nfc_pkg::NFC_OP_READ: second_code = `NFC_CMD_READ_EXEC;
      nfc_pkg::NFC_OP_PROGRAM: second_code = `NFC_CMD_PROG_CONFIRM;
      default: second_code = `NFC_CMD_ERASE_CONFIRM;
    endcase
  endfunction

  // ----------------------------------------
  // Request acceptance
  // ----------------------------------------
  // Busy die takes only reset and status
  assign busy_ok = rb_in[cmd_die_in] || (cmd_op_in == nfc_pkg::NFC_OP_RESET) ||
                   (cmd_op_in == nfc_pkg::NFC_OP_STATUS);
  assign cmd_ready_out = (state_reg == nfc_pkg::NFC_ST_IDLE) && busy_ok;
  assign bus_state = (state_reg == nfc_pkg::NFC_ST_CMD1) || (state_reg == nfc_pkg::NFC_ST_ADDR) ||
                     (state_reg == nfc_pkg::NFC_ST_DATA) || (state_reg == nfc_pkg::NFC_ST_CMD2) ||
                     (state_reg == nfc_pkg::NFC_ST_READ);
  assign wr_ready_out = (state_reg == nfc_pkg::NFC_ST_DATA) && !pend_reg;

  // ----------------------------------------
  // Operation sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    die_next = die_reg;
    col_next = col_reg;
    row_next = row_reg;
    len_next = len_reg;
    cnt_next = cnt_reg;
    aidx_next = aidx_reg;
    alast_next = alast_reg;
    acnt_next = acnt_reg;
    wait_next = wait_reg;
    pend_next = pend_reg;
    ce_n_next = ce_n_reg;
    wp_n_next = wp_n_reg;
    done_next = 1'b0;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    eng_kind = nfc_pkg::NFC_KIND_CMD;
    eng_byte = 8'h00;
    eng_start = bus_state && !pend_reg && ((state_reg != nfc_pkg::NFC_ST_DATA) || wr_valid_in);
    unique case (state_reg)
      nfc_pkg::NFC_ST_IDLE: begin
        if (cmd_valid_in && cmd_ready_out) begin
          op_next = cmd_op_in;
          die_next = cmd_die_in;
          // Identification takes one zero address byte
          col_next = (cmd_op_in == nfc_pkg::NFC_OP_READ_ID) ? 12'h000 : cmd_col_in;
          row_next = cmd_row_in;
          // Transfer length capped at 2112 bytes, whatever the start column
          len_next = (cmd_len_in > `NFC_LAST_COLUMN) ? `NFC_LAST_COLUMN : cmd_len_in;
          if (cmd_op_in == nfc_pkg::NFC_OP_STATUS) begin
            len_next = 12'h000;
          end
          cnt_next = 12'h000;
          acnt_next = 3'h0;
          // Erase addresses a block by row only
          aidx_next = (cmd_op_in == nfc_pkg::NFC_OP_ERASE) ? `NFC_ADDR_FIRST_ROW : `NFC_ADDR_FIRST_COL;
          // Five cycles for page access, one for identification
          alast_next = (cmd_op_in == nfc_pkg::NFC_OP_READ_ID) ? `NFC_ADDR_FIRST_COL : `NFC_ADDR_LAST;
          // Only the addressed die is selected
          ce_n_next = ~(4'h1 << cmd_die_in);
          // Protection lifted only for program and erase
          wp_n_next = (cmd_op_in == nfc_pkg::NFC_OP_PROGRAM) || (cmd_op_in == nfc_pkg::NFC_OP_ERASE);
          state_next = nfc_pkg::NFC_ST_CMD1;
        end
      end
      nfc_pkg::NFC_ST_CMD1: begin
        eng_byte = first_code(op_reg);
        if (eng_done) begin
          if (op_reg == nfc_pkg::NFC_OP_RESET) begin
            wait_next = `NFC_SETTLE_CYC;
            state_next = nfc_pkg::NFC_ST_WAITB;
          end else if (op_reg == nfc_pkg::NFC_OP_STATUS) begin
            state_next = nfc_pkg::NFC_ST_READ;
          end else begin
            state_next = nfc_pkg::NFC_ST_ADDR;
          end
        end
      end
      nfc_pkg::NFC_ST_ADDR: begin
        // Column bytes first, then row bytes
        eng_kind = nfc_pkg::NFC_KIND_ADDR;
        unique case (aidx_reg)
          3'h0: eng_byte = col_reg[7:0];
          3'h1: eng_byte = {4'h0, col_reg[11:8]};
          3'h2: eng_byte = row_reg[7:0];
          3'h3: eng_byte = row_reg[15:8];
          default: eng_byte = {5'h00, row_reg[18:16]};
        endcase
        if (eng_done) begin
          acnt_next = acnt_reg + 3'h1;
          aidx_next = aidx_reg + 3'h1;
          if (aidx_reg == alast_reg) begin
            unique case (op_reg)
              nfc_pkg::NFC_OP_PROGRAM: state_next = nfc_pkg::NFC_ST_DATA;
              nfc_pkg::NFC_OP_READ_ID: state_next = nfc_pkg::NFC_ST_READ;
              default: state_next = nfc_pkg::NFC_ST_CMD2;
            endcase
          end
        end
      end
      nfc_pkg::NFC_ST_DATA: begin
        eng_kind = nfc_pkg::NFC_KIND_WDATA;
        eng_byte = wr_data_in;
        if (eng_done) begin
          cnt_next = cnt_reg + 12'h001;
          if (cnt_reg == len_reg) begin
            cnt_next = 12'h000;
            state_next = nfc_pkg::NFC_ST_CMD2;
          end
        end
      end
      nfc_pkg::NFC_ST_CMD2: begin
        eng_byte = second_code(op_reg);
        if (eng_done) begin
          wait_next = `NFC_SETTLE_CYC;
          state_next = nfc_pkg::NFC_ST_WAITB;
        end
      end
      nfc_pkg::NFC_ST_WAITB: begin
        // Ready/busy needs time to fall before it is trusted
        if (wait_reg != 4'h0) begin
          wait_next = wait_reg - 4'h1;
        end else if (rb_in[die_reg]) begin
          state_next = (op_reg == nfc_pkg::NFC_OP_READ) ? nfc_pkg::NFC_ST_READ : nfc_pkg::NFC_ST_DONE;
        end
      end
      nfc_pkg::NFC_ST_READ: begin
        // Sequential bytes, column advanced by the device
        eng_kind = nfc_pkg::NFC_KIND_RDATA;
        if (eng_done) begin
          rd_valid_next = 1'b1;
          rd_data_next = eng_rdata;
          cnt_next = cnt_reg + 12'h001;
          if (cnt_reg == len_reg) begin
            state_next = nfc_pkg::NFC_ST_DONE;
          end
        end
      end
      nfc_pkg::NFC_ST_DONE: begin
        ce_n_next = 4'hF;
        wp_n_next = 1'b0;
        done_next = 1'b1;
        state_next = nfc_pkg::NFC_ST_IDLE;
      end
    endcase
    if (eng_start) begin
      pend_next = 1'b1;
    end else if (eng_done) begin
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= nfc_pkg::NFC_ST_IDLE;
      op_reg <= nfc_pkg::NFC_OP_READ;
      die_reg <= 2'h0;
      col_reg <= 12'h000;
      row_reg <= 19'h00000;
      len_reg <= 12'h000;
      cnt_reg <= 12'h000;
      aidx_reg <= 3'h0;
      alast_reg <= 3'h0;
      acnt_reg <= 3'h0;
      wait_reg <= 4'h0;
      pend_reg <= 1'b0;
      ce_n_reg <= 4'hF;
      wp_n_reg <= 1'b0;
      done_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      die_reg <= die_next;
      col_reg <= col_next;
      row_reg <= row_next;
      len_reg <= len_next;
      cnt_reg <= cnt_next;
      aidx_reg <= aidx_next;
      alast_reg <= alast_next;
      acnt_reg <= acnt_next;
      wait_reg <= wait_next;
      pend_reg <= pend_next;
      ce_n_reg <= ce_n_next;
      wp_n_reg <= wp_n_next;
      done_reg <= done_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign ce_n_out = ce_n_reg;
  assign wp_n_out = wp_n_reg;
  assign done_out = done_reg;
  assign rd_valid_out = rd_valid_reg;
  assign rd_data_out = rd_data_reg;

  nfc_bus_cycle u_cycle (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(eng_start),
    .kind_in(eng_kind),
    .byte_in(eng_byte),
    .done_out(eng_done),
    .rdata_out(eng_rdata),
    .cle_out(cle_out),
    .ale_out(ale_out),
    .we_n_out(we_n_out),
    .output_strobe_n_out(output_strobe_n_out),
    .io_out(io_out),
    .io_oe_n_out(io_oe_n_out),
    .io_in(io_in)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_one_die_selected: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $countones(~ce_n_reg) <= 1) else $error("more than one die selected");
  a_busy_refuse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (cle_out && !we_n_out && !rb_in[die_reg]) |->
    (io_out == `NFC_CMD_RESET || io_out == `NFC_CMD_STATUS))
    else $error("command sent to busy die");
  a_addr_cycles: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == nfc_pkg::NFC_ST_CMD2) |->
    (acnt_reg == ((op_reg == nfc_pkg::NFC_OP_ERASE) ? `NFC_ADDR_CYC_BLOCK : `NFC_ADDR_CYC_PAGE)))
    else $error("wrong number of address cycles");
  a_wp_during_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg != nfc_pkg::NFC_ST_IDLE && state_reg != nfc_pkg::NFC_ST_DONE &&
     (op_reg == nfc_pkg::NFC_OP_PROGRAM || op_reg == nfc_pkg::NFC_OP_ERASE)) |-> wp_n_reg)
    else $error("write protect low during program or erase");
  a_wp_idle_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(done_reg) |-> (!wp_n_reg && ce_n_reg == 4'hF)) else $error("pins not parked after op");
  a_setup_code: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (eng_start && state_reg == nfc_pkg::NFC_ST_CMD1 && op_reg == nfc_pkg::NFC_OP_PROGRAM) |->
    ##1 (cle_out && io_out == `NFC_CMD_PROG_SETUP)) else $error("program setup code wrong");
  a_wait_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == nfc_pkg::NFC_ST_WAITB && wait_reg != 4'h0) |=> (state_reg == nfc_pkg::NFC_ST_WAITB))
    else $error("busy wait cut short");
  a_leave_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == nfc_pkg::NFC_ST_WAITB && state_next != nfc_pkg::NFC_ST_WAITB) |->
    (rb_in[die_reg] && wait_reg == 4'h0)) else $error("left busy wait while die busy");

endmodule // nfc_host

// ==== hdl/nfc_params.svh ====
// Timing counts and command codes for the NAND flash host port controller
// What this block does
// - Command bytes go out with the command latch strobe high across the write strobe.
// - Address bytes go out with the address latch strobe high, only in address cycles.
// - Every written byte is a low pulse of write strobe under a low chip select.
// - Read and program send five address cycles: two column then three row.
// - Erase sends three row cycles between setup 60h and confirm D0h.
// - Page read is 00h, address cycles, then 30h to start the array transfer.
// - Page program is 80h, five address cycles, data, then 10h to start.
// - Each stacked die has its own chip select and its own ready/busy line.
`ifndef NFC_PARAMS_SVH
`define NFC_PARAMS_SVH

// ----------------------------------------
// Clock and strobe timing
// ----------------------------------------
`define NFC_CLK_NS 25
`define NFC_CEIL_CYC(ns) (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_STROBE_LOW_NS 25
`define NFC_STROBE_HIGH_NS 25
`define NFC_OUTPUT_ACCESS_DELAY_NS 30
`define NFC_BUSY_SETTLE_NS 100
`define NFC_WE_LOW_CYC 4'(`NFC_CEIL_CYC(`NFC_STROBE_LOW_NS))
`define NFC_HIGH_CYC 4'(`NFC_CEIL_CYC(`NFC_STROBE_HIGH_NS))
`define NFC_RD_LOW_CYC 4'(`NFC_CEIL_CYC(`NFC_OUTPUT_ACCESS_DELAY_NS))
`define NFC_SETTLE_CYC 4'(`NFC_CEIL_CYC(`NFC_BUSY_SETTLE_NS))

// ----------------------------------------
// Command codes and geometry
// ----------------------------------------
`define NFC_CMD_READ_SETUP 8'h00
`define NFC_CMD_READ_EXEC 8'h30
`define NFC_CMD_PROG_SETUP 8'h80
`define NFC_CMD_PROG_CONFIRM 8'h10
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_ERASE_CONFIRM 8'hD0
`define NFC_CMD_RESET 8'hFF
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_READ_ID 8'h90
`define NFC_LAST_COLUMN 12'h83F
`define NFC_ADDR_FIRST_COL 3'h0
`define NFC_ADDR_FIRST_ROW 3'h2
`define NFC_ADDR_LAST 3'h4
`define NFC_ADDR_CYC_PAGE 3'h5
`define NFC_ADDR_CYC_BLOCK 3'h3

`endif

// ==== hdl/nfc_pkg.sv ====
// Types shared by the NAND flash host port controller
package nfc_pkg;

  typedef enum logic [2:0] {
    NFC_OP_READ = 3'h0,
    NFC_OP_PROGRAM = 3'h1,
    NFC_OP_ERASE = 3'h2,
    NFC_OP_RESET = 3'h3,
    NFC_OP_STATUS = 3'h4,
    NFC_OP_READ_ID = 3'h5
  } nfc_op_t;

  typedef enum logic [1:0] {
    NFC_KIND_CMD = 2'h0,
    NFC_KIND_ADDR = 2'h1,
    NFC_KIND_WDATA = 2'h2,
    NFC_KIND_RDATA = 2'h3
  } nfc_kind_t;

  typedef enum logic [3:0] {
    NFC_CY_IDLE = 4'h1,
    NFC_CY_SETUP = 4'h2,
    NFC_CY_LOW = 4'h4,
    NFC_CY_HIGH = 4'h8
  } nfc_cyc_state_t;

  typedef enum logic [7:0] {
    NFC_ST_IDLE = 8'h01,
    NFC_ST_CMD1 = 8'h02,
    NFC_ST_ADDR = 8'h04,
    NFC_ST_DATA = 8'h08,
    NFC_ST_CMD2 = 8'h10,
    NFC_ST_WAITB = 8'h20,
    NFC_ST_READ = 8'h40,
    NFC_ST_DONE = 8'h80
  } nfc_state_t;

endpackage : nfc_pkg

// ==== sim/nfc_flash_model.sv ====
// Behavioural four-die flash device facing the host port
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter int BUSY_NS = 400,
  parameter int ACC_NS = 20,
  // Arbitrary identity value
  parameter logic [7:0] ID_BYTE = 8'h5C,
  parameter logic [7:0] STATUS_OK = 8'hC0
) (
  // Flash pins
  input wire logic [3:0] ce_n_in,
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic output_strobe_n_in,
  input wire logic wp_n_in,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic [3:0] rb_out
);
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] addr_reg [5];
  logic [7:0] mem [longint];
  logic [7:0] pbuf [int];
  logic [3:0] busy = 4'h0;
  logic [11:0] col = 12'h000;
  logic wp_seen = 1'b0;
  int acnt = 0;
  int seen = 0;
  // open drain per die, pulled high
  assign rb_out = ~busy;
  initial io_out = 8'h00;
  function automatic int sel();
    for (int i = 0; i < 4; i++) if (!ce_n_in[i]) return i;
    return -1;
  endfunction
  // Each die keeps its own array
  function automatic longint row_key(int d);
    return (longint'(d) << 32) + longint'({addr_reg[4][2:0], addr_reg[3], addr_reg[2], 12'h000});
  endfunction
  // timer runs whatever chip select does
  task automatic go_busy(int d);
    busy[d] = 1'b1;
    #(BUSY_NS) busy[d] = 1'b0;
  endtask
  // byte latched on write strobe rise
  always @(posedge we_n_in) begin
    int d;
    d = sel();
    // busy die takes only FF and 70
    if (d >= 0 && cle_in && (!busy[d] || io_in == 8'hFF || io_in == 8'h70)) begin
      cmd_reg = io_in;
      wp_seen = wp_n_in;
      if (io_in inside {8'h00, 8'h80, 8'h90, 8'h60}) begin
        seen = 0;
        acnt = (io_in == 8'h60) ? 2 : 0;
      end
      if (io_in == 8'h80) pbuf.delete();
      if (io_in == 8'h10 && wp_n_in) foreach (pbuf[k]) mem[row_key(d) + k] = pbuf[k];
      if (io_in inside {8'h30, 8'hFF} || (io_in inside {8'h10, 8'hD0} && wp_n_in)) begin
        fork
          go_busy(d);
        join_none
      end
    end else if (d >= 0 && ale_in) begin
      seen++;
      if (acnt < ((cmd_reg == 8'h90) ? 1 : 5)) addr_reg[acnt] = io_in;
      acnt++;
      col = {addr_reg[1][3:0], addr_reg[0]};
    end else if (d >= 0 && cmd_reg == 8'h80) begin
      pbuf[col] = io_in;
      col++;
    end
  end
  // late byte, column steps by one, else junk
  always @(negedge output_strobe_n_in) begin
    int d;
    logic [7:0] drv;
    d = sel();
    drv = ~io_out;
    if (d >= 0 && cmd_reg == 8'h70) drv = busy[d] ? (STATUS_OK & 8'hBF) : STATUS_OK;
    else if (d >= 0 && cmd_reg == 8'h90) drv = ID_BYTE;
    else if (d >= 0) begin
      drv = mem.exists(row_key(d) + col) ? mem[row_key(d) + col] : 8'hFF;
      col++;
    end
    io_out = ~io_out;
    #(ACC_NS) io_out = drv;
  end
  // Short hold, then the released bus shows no stale value
  always @(posedge output_strobe_n_in) #5 io_out = ~io_out;
endmodule // nfc_flash_model

// ==== sim/nfc_host_tb.sv ====
// Self-checking bench for the flash host port controller
`timescale 1ns/1ps
module nfc_host_tb;
  logic clk_in, rst_n_in, cmd_valid_in, cmd_ready_out, done_out, wr_valid_in, wr_ready_out, rd_valid_out;
  logic cle_out, ale_out, we_n_out, output_strobe_n_out, wp_n_out, io_oe_n_out;
  nfc_pkg::nfc_op_t cmd_op_in;
  logic [1:0] cmd_die_in;
  logic [11:0] cmd_col_in, cmd_len_in;
  logic [18:0] cmd_row_in;
  logic [7:0] wr_data_in, rd_data_out, io_out, dev_io, io_bus;
  logic [3:0] ce_n_out, rb_in;
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  int fail_count = 0;
  int samples_checked = 0;
  assign io_bus = io_oe_n_out ? dev_io : io_out;
  nfc_host i_dut (.clk_in, .rst_n_in, .cmd_valid_in, .cmd_ready_out, .cmd_op_in, .cmd_die_in, .cmd_col_in,
    .cmd_row_in, .cmd_len_in, .done_out, .wr_data_in, .wr_valid_in, .wr_ready_out, .rd_data_out, .rd_valid_out,
    .ce_n_out, .cle_out, .ale_out, .we_n_out, .output_strobe_n_out, .wp_n_out, .io_out, .io_oe_n_out,
    .io_in(io_bus), .rb_in);
  nfc_flash_model i_flash (.ce_n_in(ce_n_out), .cle_in(cle_out), .ale_in(ale_out), .we_n_in(we_n_out),
    .output_strobe_n_in(output_strobe_n_out), .wp_n_in(wp_n_out), .io_in(io_bus), .io_out(dev_io), .rb_out(rb_in));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Column at the second-last spare byte so a two-byte transfer ends on the last spare byte
  task automatic run_op(nfc_pkg::nfc_op_t op, logic [1:0] die, logic [11:0] len);
    int n;
    logic tk;
    logic wk;
    logic dn;
    n = 0;
    dn = 1'b0;
    rq = {};
    @(posedge clk_in);
    cmd_op_in <= op;
    cmd_die_in <= die;
    cmd_col_in <= 12'h83E;
    cmd_row_in <= 19'h4ABCD;
    cmd_len_in <= len;
    cmd_valid_in <= 1'b1;
    wr_valid_in <= wq.size() > 0;
    wr_data_in <= (wq.size() > 0) ? wq[0] : 8'h00;
    while (!dn && n < 4000) begin
      @(negedge clk_in);
      tk = cmd_valid_in && cmd_ready_out;
      wk = wr_valid_in && wr_ready_out;
      dn = done_out === 1'b1;
      if (rd_valid_out === 1'b1) rq.push_back(rd_data_out);
      @(posedge clk_in);
      if (tk) cmd_valid_in <= 1'b0;
      if (wk) begin
        void'(wq.pop_front());
        wr_valid_in <= wq.size() > 0;
        wr_data_in <= (wq.size() > 0) ? wq[0] : 8'h00;
      end
      n++;
    end
    check("done", 8'h01, 8'(dn));
  endtask
  task automatic t_idle();
    @(negedge clk_in);
    check("ce_n idle", 8'h0F, 8'(ce_n_out));
    check("wp_n idle", 8'h00, 8'(wp_n_out));
    check("io_oe_n idle", 8'h01, 8'(io_oe_n_out));
  endtask
  task automatic t_prog_read();
    wq = {8'hA5, 8'h5A};
    run_op(nfc_pkg::NFC_OP_PROGRAM, 2'h1, 12'h001);
    check("prog addr cycles", 8'h05, 8'(i_flash.seen));
    check("prog wp_n", 8'h01, 8'(i_flash.wp_seen));
    run_op(nfc_pkg::NFC_OP_READ, 2'h1, 12'h001);
    check("read addr cycles", 8'h05, 8'(i_flash.seen));
    check("read count", 8'h02, 8'(rq.size()));
    check("spare byte 0", 8'hA5, rq[0]);
    check("spare byte 1", 8'h5A, rq[1]);
    run_op(nfc_pkg::NFC_OP_READ, 2'h2, 12'h000);
    check("other die", 8'hFF, rq[0]);
  endtask
  task automatic t_erase();
    run_op(nfc_pkg::NFC_OP_ERASE, 2'h2, 12'h000);
    check("erase addr cycles", 8'h03, 8'(i_flash.seen));
    check("erase confirm", 8'hD0, i_flash.cmd_reg);
  endtask
  task automatic t_single();
    run_op(nfc_pkg::NFC_OP_STATUS, 2'h0, 12'h000);
    check("status", i_flash.STATUS_OK, rq[0]);
    run_op(nfc_pkg::NFC_OP_READ_ID, 2'h3, 12'h000);
    check("id byte", i_flash.ID_BYTE, rq[0]);
    run_op(nfc_pkg::NFC_OP_RESET, 2'h0, 12'h000);
    check("reset code", 8'hFF, i_flash.cmd_reg);
  endtask
  // Busy die refuses erase but still answers status
  task automatic t_busy();
    fork
      i_flash.go_busy(0);
    join_none
    @(posedge clk_in);
    cmd_op_in <= nfc_pkg::NFC_OP_ERASE;
    cmd_die_in <= 2'h0;
    cmd_valid_in <= 1'b1;
    repeat (2) @(negedge clk_in);
    check("ready busy", 8'h00, 8'(cmd_ready_out));
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    run_op(nfc_pkg::NFC_OP_STATUS, 2'h0, 12'h000);
    check("busy status", i_flash.STATUS_OK & 8'hBF, rq[0]);
  endtask
  initial begin
    rst_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    wr_valid_in = 1'b0;
    cmd_op_in = nfc_pkg::NFC_OP_STATUS;
    cmd_die_in = 2'h0;
    cmd_col_in = 12'h000;
    cmd_row_in = 19'h00000;
    cmd_len_in = 12'h000;
    wr_data_in = 8'h00;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_idle();
    t_prog_read();
    t_erase();
    t_single();
    t_busy();
    wrap_up();
  end
  // Ops here take a few thousand cycles at most
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end
endmodule // nfc_host_tb
